//--- include/dcl_pkg.sv
`default_nettype none
package dcl_pkg;

    // ==========================================================
    // Bus shape
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W  = 7;

    // ==========================================================
    // Register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_OUTPUT_CODE_FAST   = 7'h29;
    localparam logic [IDX_W-1:0] IDX_SOFT_LOAD_FAST     = 7'h32;
    localparam logic [IDX_W-1:0] IDX_INPUT_CODE_FAST    = 7'h33;
    localparam logic [IDX_W-1:0] IDX_HARD_LOAD_MASK     = 7'h37;
    localparam logic [IDX_W-1:0] IDX_OUTPUT_CODE_PREC   = 7'h38;
    localparam logic [IDX_W-1:0] IDX_OUTPUT_PAGE_PREC   = 7'h3E;
    localparam logic [IDX_W-1:0] IDX_PAGE_SELECT_PREC   = 7'h41;
    localparam logic [IDX_W-1:0] IDX_INPUT_PAGE_PREC    = 7'h42;
    localparam logic [IDX_W-1:0] IDX_INPUT_CODE_PREC    = 7'h46;

    // ==========================================================
    // Field layout and reset values
    localparam int CODE_W    = 16;
    localparam int PREC_LSB  = 8;
    localparam int PREC_MSB  = 23;
    localparam int FAST_MSB  = 15;
    localparam int CTRL_BIT  = 0;
    localparam logic [CODE_W-1:0] CODE_RST = 16'h0000;
    localparam logic              BIT_RST  = 1'b0;
    localparam logic [1:0]        WORD_LSB = 2'h0;
    localparam logic [DATA_W-1:0] RD_ZERO  = 32'h0000_0000;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [DATA_W-1:0] pwdata;
    } dcl_apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } dcl_apb_rsp_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_ACCESS = 2'b10
    } dcl_state_t;

endpackage
`default_nettype wire

//--- rtl/dcl_regs.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
module dcl_regs (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire dcl_pkg::dcl_apb_req_t apb_req,
    output var  dcl_pkg::dcl_apb_rsp_t apb_rsp,
    input  wire logic                  load_strobe_n,
    output var  logic [15:0]           output_code_fast,
    output var  logic [15:0]           output_code_precise
);
    import dcl_pkg::*;

    // ==========================================================
    // Storage
    dcl_state_t        state_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic              pready_reg;
    logic              pslverr_reg;
    logic [CODE_W-1:0] in_fast_reg;
    logic [CODE_W-1:0] out_fast_reg;
    logic [CODE_W-1:0] in_prec_reg;
    logic [CODE_W-1:0] out_prec_reg;
    logic [CODE_W-1:0] page_out_reg;
    logic [CODE_W-1:0] page_in_reg;
    logic              mask_reg;
    logic              sel_reg;
    logic              pin_s1_reg;
    logic              pin_s2_reg;
    logic              pin_d_reg;

    // ==========================================================
    // Decode
    logic [IDX_W-1:0]  idx;
    logic              aligned;
    logic              setup;
    logic              acc_wr;
    logic              hit;
    logic [DATA_W-1:0] rd_mux;
    logic [CODE_W-1:0] wr_fast;
    logic [CODE_W-1:0] wr_prec;
    logic              wr_bit;
    logic              pin_evt;
    logic              soft_ld;
    logic              ld_fast;
    logic              ld_prec;
    logic              w_out_fast;
    logic              w_in_fast;
    logic              w_mask;
    logic              w_out_prec;
    logic              w_page_out;
    logic              w_sel;
    logic              w_page_in;
    logic              w_in_prec;

    assign idx     = apb_req.paddr[IDX_W+1:2];
    assign aligned = (apb_req.paddr[1:0] == WORD_LSB)
                   && (apb_req.paddr[ADDR_W-1:IDX_W+2] == '0);
    assign setup   = apb_req.psel && !apb_req.penable;
    assign acc_wr  = (state_reg == ST_ACCESS) && apb_req.psel
                   && apb_req.penable && apb_req.pwrite
                   && !pslverr_reg;
    assign wr_fast = apb_req.pwdata[FAST_MSB:0];
    assign wr_prec = apb_req.pwdata[PREC_MSB:PREC_LSB];
    assign wr_bit  = apb_req.pwdata[CTRL_BIT];

    assign w_out_fast = acc_wr && (idx == IDX_OUTPUT_CODE_FAST);
    assign soft_ld    = acc_wr && (idx == IDX_SOFT_LOAD_FAST)
                      && wr_bit;
    assign w_in_fast  = acc_wr && (idx == IDX_INPUT_CODE_FAST);
    assign w_mask     = acc_wr && (idx == IDX_HARD_LOAD_MASK);
    assign w_out_prec = acc_wr && (idx == IDX_OUTPUT_CODE_PREC);
    assign w_page_out = acc_wr && (idx == IDX_OUTPUT_PAGE_PREC);
    assign w_sel      = acc_wr && (idx == IDX_PAGE_SELECT_PREC);
    assign w_page_in  = acc_wr && (idx == IDX_INPUT_PAGE_PREC);
    assign w_in_prec  = acc_wr && (idx == IDX_INPUT_CODE_PREC);

    // Pin load counts only while unmasked; soft load copies the fast code only and ignores the mask
    assign pin_evt = !pin_s2_reg && pin_d_reg;
    assign ld_fast = (pin_evt && !mask_reg) || soft_ld;
    assign ld_prec = pin_evt && !mask_reg;

    // ==========================================================
    // Read mux and address check
    always_comb begin
        hit    = aligned;
        rd_mux = RD_ZERO;
        unique case (idx)
            IDX_OUTPUT_CODE_FAST: rd_mux[FAST_MSB:0] = out_fast_reg;
            IDX_SOFT_LOAD_FAST:   rd_mux = RD_ZERO;
            IDX_INPUT_CODE_FAST:  rd_mux[FAST_MSB:0] = in_fast_reg;
            IDX_HARD_LOAD_MASK:   rd_mux[CTRL_BIT] = mask_reg;
            IDX_OUTPUT_CODE_PREC: rd_mux[PREC_MSB:PREC_LSB] = out_prec_reg;
            IDX_OUTPUT_PAGE_PREC: rd_mux[PREC_MSB:PREC_LSB] = page_out_reg;
            IDX_PAGE_SELECT_PREC: rd_mux[CTRL_BIT] = sel_reg;
            IDX_INPUT_PAGE_PREC:  rd_mux[PREC_MSB:PREC_LSB] = page_in_reg;
            IDX_INPUT_CODE_PREC:  rd_mux[PREC_MSB:PREC_LSB] = in_prec_reg;
            default:              hit = 1'b0;
        endcase
    end

    // ==========================================================
    // Bus phase tracking, no wait states: pready is high in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE:   state_reg <= setup ? ST_ACCESS : ST_IDLE;
                ST_ACCESS: state_reg <= ST_IDLE;
                default:   state_reg <= ST_IDLE;
            endcase
        end
    end

    // Answer is captured at setup so every output leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= RD_ZERO;
        end else if (state_reg == ST_IDLE && setup) begin
            pready_reg  <= 1'b1;
            pslverr_reg <= !hit;
            prdata_reg  <= (apb_req.pwrite || !hit) ? RD_ZERO : rd_mux;
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= RD_ZERO;
        end
    end

    // ==========================================================
    // Load pin synchroniser and edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
            pin_d_reg  <= 1'b1;
        end else begin
            pin_s1_reg <= load_strobe_n;
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg  <= pin_s2_reg;
        end
    end

    // ==========================================================
    // Control bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= BIT_RST;
            sel_reg  <= BIT_RST;
        end else begin
            if (w_mask) begin
                mask_reg <= wr_bit;
            end
            if (w_sel) begin
                sel_reg <= wr_bit;
            end
        end
    end

    // ==========================================================
    // Fast mode codes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_fast_reg <= CODE_RST;
        end else if (w_in_fast) begin
            in_fast_reg <= wr_fast;
        end
    end

    // Direct writes win over a load in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_fast_reg <= CODE_RST;
        end else if (w_out_fast) begin
            out_fast_reg <= wr_fast;
        end else if (ld_fast) begin
            out_fast_reg <= in_fast_reg;
        end
    end

    // ==========================================================
    // Precision mode pages and codes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_out_reg <= CODE_RST;
            page_in_reg  <= CODE_RST;
        end else begin
            if (w_page_out) begin
                page_out_reg <= wr_prec;
            end
            if (w_page_in) begin
                page_in_reg <= wr_prec;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_prec_reg <= CODE_RST;
        end else if (w_in_prec) begin
            in_prec_reg <= wr_prec;
        end else if (w_page_in && sel_reg) begin
            in_prec_reg <= wr_prec;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_prec_reg <= CODE_RST;
        end else if (w_out_prec) begin
            out_prec_reg <= wr_prec;
        end else if (w_page_out && sel_reg) begin
            out_prec_reg <= wr_prec;
        end else if (ld_prec) begin
            out_prec_reg <= in_prec_reg;
        end
    end

    // ==========================================================
    // Outputs
    assign apb_rsp.prdata      = prdata_reg;
    assign apb_rsp.pready      = pready_reg;
    assign apb_rsp.pslverr     = pslverr_reg;
    assign output_code_fast    = out_fast_reg;
    assign output_code_precise = out_prec_reg;

    // ==========================================================
    // Checks
    sequence s_setup_idle;
        state_reg == ST_IDLE && setup;
    endsequence

    sequence s_soft_wr(logic v);
        acc_wr && idx == IDX_SOFT_LOAD_FAST && wr_bit == v;
    endsequence

    property p_answer_next;
        @(posedge pclk) disable iff (!presetn)
        s_setup_idle |=> pready_reg ##1 !pready_reg;
    endproperty
    a_answer_next: assert property (p_answer_next)
        else $error("pready not one cycle after setup");

    property p_soft_load;
        @(posedge pclk) disable iff (!presetn)
        s_soft_wr(1'b1) and (!w_out_fast)
            |=> out_fast_reg == $past(in_fast_reg);
    endproperty
    a_soft_load: assert property (p_soft_load)
        else $error("soft load did not copy input code");

    property p_soft_zero;
        @(posedge pclk) disable iff (!presetn)
        s_soft_wr(1'b0) and (!pin_evt) |=> $stable(out_fast_reg);
    endproperty
    a_soft_zero: assert property (p_soft_zero)
        else $error("soft load zero changed output");

    property p_soft_reads_zero;
        @(posedge pclk) disable iff (!presetn)
        s_setup_idle and (!apb_req.pwrite && aligned
            && idx == IDX_SOFT_LOAD_FAST) |=> prdata_reg == RD_ZERO;
    endproperty
    a_soft_reads_zero: assert property (p_soft_reads_zero)
        else $error("soft load register read not zero");

    property p_pin_load;
        @(posedge pclk) disable iff (!presetn)
        pin_evt && !mask_reg && !w_out_prec && !w_page_out
            |=> out_prec_reg == $past(in_prec_reg);
    endproperty
    a_pin_load: assert property (p_pin_load)
        else $error("unmasked pin load did not latch");

    property p_pin_masked;
        @(posedge pclk) disable iff (!presetn)
        pin_evt && mask_reg && !w_out_prec && !w_page_out
            |=> $stable(out_prec_reg);
    endproperty
    a_pin_masked: assert property (p_pin_masked)
        else $error("masked pin load changed output");

    property p_page_copy;
        @(posedge pclk) disable iff (!presetn)
        w_page_out && sel_reg |=> out_prec_reg == $past(wr_prec);
    endproperty
    a_page_copy: assert property (p_page_copy)
        else $error("output page not copied with select set");

    property p_page_no_copy;
        @(posedge pclk) disable iff (!presetn)
        w_page_in && !sel_reg |=> $stable(in_prec_reg);
    endproperty
    a_page_no_copy: assert property (p_page_no_copy)
        else $error("input page copied with select clear");

    property p_reset_zero;
        @(posedge pclk) disable iff (!presetn)
        !$past(presetn) |-> out_prec_reg == CODE_RST
            && page_in_reg == CODE_RST;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("code registers not zero after reset");

    property p_prec_low_zero;
        @(posedge pclk) disable iff (!presetn)
        s_setup_idle and (!apb_req.pwrite && aligned
            && idx == IDX_OUTPUT_CODE_PREC)
            |=> prdata_reg[PREC_LSB-1:0] == '0
                && prdata_reg[PREC_MSB:PREC_LSB] == $past(out_prec_reg);
    endproperty
    a_prec_low_zero: assert property (p_prec_low_zero)
        else $error("precision output read wrong");

    property p_fast_in_write;
        @(posedge pclk) disable iff (!presetn)
        w_in_fast |=> in_fast_reg == $past(wr_fast);
    endproperty
    a_fast_in_write: assert property (p_fast_in_write)
        else $error("fast input code write not stored");

    property p_page_in_copy;
        @(posedge pclk) disable iff (!presetn)
        w_page_in && sel_reg |=> in_prec_reg == $past(wr_prec);
    endproperty
    a_page_in_copy: assert property (p_page_in_copy)
        else $error("input page not copied with select set");

    property p_unmapped_err;
        @(posedge pclk) disable iff (!presetn)
        s_setup_idle and (!hit) |=> pslverr_reg && prdata_reg == RD_ZERO;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("unmapped access not refused");

endmodule // dcl_regs
`default_nettype wire

//--- verification/dcl_pin_host.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Host side of the load pin: one low pulse of LOW_CYC cycles per request
module dcl_pin_host #(
    parameter int LOW_CYC = 3
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pulse_req,
    output var  logic load_strobe_n
);
    int cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt           <= 0;
            load_strobe_n <= 1'b1;
        end else if (pulse_req && cnt == 0) begin
            cnt           <= LOW_CYC;
            load_strobe_n <= 1'b0;
        end else if (cnt > 0) begin
            cnt           <= cnt - 1;
            load_strobe_n <= (cnt == 1);
        end
    end
endmodule // dcl_pin_host
`default_nettype wire

//--- verification/dac_code_load_registers_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dac_code_load_registers_tb;
    import dcl_pkg::*;

    logic         pclk;
    logic         presetn;
    logic         pulse_req;
    logic         load_strobe_n;
    dcl_apb_req_t req;
    dcl_apb_rsp_t rsp;
    logic [15:0]  out_fast;
    logic [15:0]  out_prec;
    logic [31:0]  rdata;
    logic         slverr;
    int           fails = 0;
    int           compares = 0;
    int           cyc = 0;

    dcl_regs dut (
        .pclk                (pclk),
        .presetn             (presetn),
        .apb_req             (req),
        .apb_rsp             (rsp),
        .load_strobe_n       (load_strobe_n),
        .output_code_fast    (out_fast),
        .output_code_precise (out_prec)
    );

    dcl_pin_host host (
        .pclk          (pclk),
        .presetn       (presetn),
        .pulse_req     (pulse_req),
        .load_strobe_n (load_strobe_n)
    );

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // ==========================================================
    // Closing report and hang guard
    task automatic tally_and_finish();
        $display("Compares %0d, fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            $display("Error at %0t: timeout", $time);
            tally_and_finish();
        end
    end

    // ==========================================================
    // APB master and checks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic [IDX_W-1:0] idx, input logic wr, input logic [31:0] wd);
        @(posedge pclk);
        req <= '{paddr: {3'h0, idx, WORD_LSB}, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (rsp.pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdata  = rsp.prdata;
        slverr = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] wd);
        apb(idx, 1'b1, wd);
    endtask

    task automatic rd(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
        apb(idx, 1'b0, 32'h0000_0000);
        chk(rdata, exp);
    endtask

    task automatic out_chk(input logic [15:0] ef, input logic [15:0] ep);
        repeat (2) @(negedge pclk);
        chk({16'h0000, out_fast}, {16'h0000, ef});
        chk({16'h0000, out_prec}, {16'h0000, ep});
    endtask

    task automatic pin_load();
        @(posedge pclk);
        pulse_req <= 1'b1;
        @(posedge pclk);
        pulse_req <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        presetn   = 1'b0;
        req       = '0;
        pulse_req = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        out_chk(16'h0000, 16'h0000);
        rd(IDX_OUTPUT_CODE_PREC, 32'h0000_0000);
        rd(IDX_INPUT_PAGE_PREC, 32'h0000_0000);
        rd(IDX_INPUT_CODE_FAST, 32'h0000_0000);
        rd(IDX_HARD_LOAD_MASK, 32'h0000_0000);
        rd(IDX_PAGE_SELECT_PREC, 32'h0000_0000);
        wr(IDX_INPUT_CODE_FAST, 32'hFFFF_A5C3);
        rd(IDX_INPUT_CODE_FAST, 32'h0000_A5C3);
        wr(IDX_SOFT_LOAD_FAST, 32'h0000_0000);
        out_chk(16'h0000, 16'h0000);
        wr(IDX_SOFT_LOAD_FAST, 32'h0000_0001);
        out_chk(16'hA5C3, 16'h0000);
        rd(IDX_SOFT_LOAD_FAST, 32'h0000_0000);
        wr(IDX_INPUT_CODE_FAST, 32'h0000_1234);
        wr(IDX_SOFT_LOAD_FAST, 32'h0000_0001);
        out_chk(16'h1234, 16'h0000);
        wr(IDX_INPUT_CODE_FAST, 32'h0000_5A5A);
        wr(IDX_INPUT_CODE_PREC, 32'h00BE_EF00);
        pin_load();
        out_chk(16'h5A5A, 16'hBEEF);
        wr(IDX_HARD_LOAD_MASK, 32'h0000_0001);
        rd(IDX_HARD_LOAD_MASK, 32'h0000_0001);
        wr(IDX_INPUT_CODE_FAST, 32'h0000_0F0F);
        wr(IDX_INPUT_CODE_PREC, 32'h0077_7700);
        pin_load();
        out_chk(16'h5A5A, 16'hBEEF);
        wr(IDX_HARD_LOAD_MASK, 32'h0000_0000);
        pin_load();
        out_chk(16'h0F0F, 16'h7777);
        wr(IDX_OUTPUT_PAGE_PREC, 32'h00CA_FE00);
        out_chk(16'h0F0F, 16'h7777);
        wr(IDX_INPUT_PAGE_PREC, 32'h00AB_CD00);
        rd(IDX_INPUT_CODE_PREC, 32'h0077_7700);
        rd(IDX_INPUT_PAGE_PREC, 32'h00AB_CD00);
        wr(IDX_PAGE_SELECT_PREC, 32'h0000_0001);
        wr(IDX_OUTPUT_PAGE_PREC, 32'hFFF0_0DFF);
        out_chk(16'h0F0F, 16'hF00D);
        rd(IDX_OUTPUT_CODE_PREC, 32'h00F0_0D00);
        rd(IDX_OUTPUT_PAGE_PREC, 32'h00F0_0D00);
        rd(IDX_OUTPUT_CODE_FAST, 32'h0000_0F0F);
        wr(IDX_OUTPUT_CODE_PREC, 32'hFF24_68FF);
        rd(IDX_OUTPUT_CODE_PREC, 32'h0024_6800);
        out_chk(16'h0F0F, 16'h2468);
        wr(IDX_INPUT_PAGE_PREC, 32'h0013_5700);
        rd(IDX_INPUT_CODE_PREC, 32'h0013_5700);
        apb(7'h10, 1'b0, 32'h0000_0000);
        chk({31'h0, slverr}, 32'h0000_0001);
        chk(rdata, 32'h0000_0000);
        tally_and_finish();
    end
endmodule // dac_code_load_registers_tb
`default_nettype wire
